// ===== include/tpx_pkg.sv
// package of constants and types for the timer, watchdog and power-down extension
package tpx_pkg;
	// apb register byte addresses
	localparam logic [7:0] ADDR_EXT_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TMR_MODE = 8'h04;
	localparam logic [7:0] ADDR_TMR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_PWR_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_TMR0_CNT = 8'h10;
	localparam logic [7:0] ADDR_TMR1_CNT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// extension control field positions
	localparam int EC_FLOAT_PD = 0;
	localparam int EC_P1_FLOAT = 1;
	localparam int EC_PULLUP_SEL = 4;
	localparam int EC_CHAIN = 6;
	localparam int EC_WDOG = 7;
	// timer control field positions
	localparam int TC_RUN0 = 0;
	localparam int TC_OVF0 = 1;
	localparam int TC_RUN1 = 2;
	localparam int TC_OVF1 = 3;
	// power control field positions
	localparam int PC_IDLE = 0;
	localparam int PC_PD = 1;
	localparam int PC_RECOVER = 2;
	localparam int PC_PIN_PD = 3;
	// timer mode field positions (per timer nibble: mode[1:0], source at bit 2)
	localparam int TM_SRC0 = 2;
	localparam int TM_SRC1 = 6;
	// reset values
	localparam logic [7:0] EXT_CTRL_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// watchdog internal reset length in machine cycles
	localparam int WDOG_RST_CYCLES = 5;
	localparam logic [2:0] WDOG_RST_LEN = 3'(WDOG_RST_CYCLES);
	// port drive modes
	typedef struct packed {
		logic float_en;
		logic high_imp;
	} tpx_port_t;
	// power states
	typedef enum logic [2:0] {
		PW_RUN = 3'b001,
		PW_IDLE = 3'b010,
		PW_DOWN = 3'b100
	} tpx_pwr_t;
endpackage : tpx_pkg

// ===== hw/tpx_top.sv
// timer chaining, watchdog, power-down control and port float logic
// Summary of operation
// - port float bit floats that port
// - float-in-powerdown floats all ports in power-down
// - ports restore impedance at wake request
// - chain bit six makes 32-bit timer/counter
// - timer0 low half, timer1 high half
// - chain bit starts; clearing reverts to mode
// - chained timer counts timer0 source events (cycle or pin), no flag0
// - full chained overflow sets timer1 flag
// - counter counts on sampled one then zero
// - watchdog bit seven makes flag1 overflow watchdog
// - watchdog source per cycle or external pin
// - watchdog overflow: flag, then 5-cycle reset
// - watchdog reset clears control register and timers
// - timers count external pins in power-down
// - power-down overflow interrupts or watchdog resets
// - recover bit resumes idle without service
// - external interrupts or counters wake power-down
// - recover selects resume versus service after wake
// - pin falling edge enters, rising edge leaves
// - combined control needs rising edge and interrupt
// - reset gives low impedance ports
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module tpx_top #(
	parameter int NUM_PORTS = 3
) (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// machine cycle strobe and pins
	input wire logic I_MACHINE_CYCLE,
	input wire logic I_TIMER_ZERO_PIN,
	input wire logic I_TIMER_ONE_PIN,
	input wire logic I_EXT_INT0,
	input wire logic I_EXT_INT1,
	// port drive control
	output logic [NUM_PORTS-1:0] O_PORT_FLOAT,
	output logic [NUM_PORTS-1:0] O_PORT_HIGH_IMP,
	// core control
	output logic O_WDOG_RESET,
	output logic O_POWERDOWN,
	output logic O_IDLE,
	output logic O_TIMER0_IRQ,
	output logic O_TIMER1_IRQ,
	output logic O_WAKE_RESUME,
	output logic O_WAKE_SERVICE
);
	initial begin
		if (NUM_PORTS != 3) $error("tpx_top serves exactly three ports");
	end

	logic [7:0] ext_ctrl;
	logic [7:0] tmr_mode;
	logic run0, run1, ovf0, ovf1;
	logic [7:0] pwr_ctrl;
	logic [15:0] cnt0, cnt1;
	logic [2:0] wd_count;
	logic wd_pending;
	tpx_pkg::tpx_pwr_t pwr_state;
	logic t0_prev, t1_prev, t1_pin_prev;
	logic pin_pd_armed;

	// apb decode
	wire logic acc = I_PSEL & I_PENABLE;
	wire logic wr = acc & I_PWRITE;
	wire logic hit_ec = I_PADDR == tpx_pkg::ADDR_EXT_CTRL;
	wire logic hit_tm = I_PADDR == tpx_pkg::ADDR_TMR_MODE;
	wire logic hit_tc = I_PADDR == tpx_pkg::ADDR_TMR_CTRL;
	wire logic hit_pc = I_PADDR == tpx_pkg::ADDR_PWR_CTRL;
	wire logic hit_c0 = I_PADDR == tpx_pkg::ADDR_TMR0_CNT;
	wire logic hit_c1 = I_PADDR == tpx_pkg::ADDR_TMR1_CNT;
	wire logic hit_st = I_PADDR == tpx_pkg::ADDR_STATUS;
	wire logic mapped = hit_ec | hit_tm | hit_tc | hit_pc | hit_c0 | hit_c1 | hit_st;

	// mode decode
	wire logic chain = ext_ctrl[tpx_pkg::EC_CHAIN];
	wire logic wdog = ext_ctrl[tpx_pkg::EC_WDOG];
	wire logic src0 = tmr_mode[tpx_pkg::TM_SRC0];
	wire logic src1 = tmr_mode[tpx_pkg::TM_SRC1];
	wire logic [1:0] mode0 = tmr_mode[1:0];
	wire logic [1:0] mode1 = tmr_mode[5:4];
	wire logic in_pd = pwr_state == tpx_pkg::PW_DOWN;

	// count events: per machine cycle or pin 1-then-0 sample; in power-down only pins
	wire logic fall0 = t0_prev & ~I_TIMER_ZERO_PIN;
	wire logic fall1 = t1_prev & ~I_TIMER_ONE_PIN;
	wire logic samp = I_MACHINE_CYCLE | in_pd;
	wire logic tick0 = src0 ? (samp & fall0) : (I_MACHINE_CYCLE & ~in_pd);
	wire logic tick1 = src1 ? (samp & fall1) : (I_MACHINE_CYCLE & ~in_pd);
	wire logic en0 = (chain | run0) & tick0 & ~O_WDOG_RESET;
	wire logic en1 = run1 & tick1 & ~chain & ~O_WDOG_RESET;

	// timer 0 next value and overflow per mode (mode 3 wraps the low byte, mode 2 loads it from the high byte)
	wire logic [16:0] sum0 = {1'b0, cnt0} + 17'h0_0001;
	wire logic [8:0] sum0l = {1'b0, cnt0[7:0]} + 9'h001;
	wire logic eight0 = ~chain & mode0[1];
	wire logic ov0 = en0 & (eight0 ? sum0l[8] : sum0[16]);
	wire logic [15:0] nx0 = eight0 ? {cnt0[15:8], (mode0[0] ? sum0l[7:0] : cnt0[15:8])} :
		sum0[15:0];
	// timer 1 advances alone or on the carry from timer 0 when chained
	wire logic step1 = chain ? ov0 : en1;
	wire logic [16:0] sum1 = {1'b0, cnt1} + 17'h0_0001;
	wire logic [8:0] sum1l = {1'b0, cnt1[7:0]} + 9'h001;
	wire logic eight1 = ~chain & mode1[1];
	wire logic ov1 = step1 & (eight1 ? sum1l[8] : sum1[16]);
	wire logic [15:0] nx1 = eight1 ? {cnt1[15:8], (mode1[0] ? sum1l[7:0] : cnt1[15:8])} :
		sum1[15:0];
	wire logic set_ovf0 = ov0 & ~chain;
	wire logic wd_fire = ov1 & wdog;

	// wake sources and pin-controlled power-down edges
	wire logic t1_rise = ~t1_pin_prev & I_TIMER_ONE_PIN;
	wire logic t1_fall = t1_pin_prev & ~I_TIMER_ONE_PIN;
	wire logic pin_pd = pwr_ctrl[tpx_pkg::PC_PIN_PD];
	wire logic irq_wake = I_EXT_INT0 | I_EXT_INT1 |
		(ov0 & src0) | (ov1 & src1 & ~wdog);
	wire logic sw_pd = pwr_ctrl[tpx_pkg::PC_PD];
	// combined control needs rise and interrupt; pin-only needs rise; software-only irq
	wire logic pd_exit = (sw_pd & pin_pd) ? (pin_pd_armed & irq_wake) :
		pin_pd ? t1_rise : irq_wake;
	wire logic idle_exit = I_EXT_INT0 | I_EXT_INT1 | ov0 | ov1;
	wire logic recover = pwr_ctrl[tpx_pkg::PC_RECOVER];

	// port modes: float in power-down only if asked, restored on wake request
	wire logic pd_float = in_pd & ext_ctrl[tpx_pkg::EC_FLOAT_PD] & ~pd_exit;
	tpx_pkg::tpx_port_t next_port [NUM_PORTS];
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			assign next_port[gi].float_en = ext_ctrl[tpx_pkg::EC_P1_FLOAT + gi] | pd_float;
			assign next_port[gi].high_imp = ~ext_ctrl[tpx_pkg::EC_P1_FLOAT + gi] &
				ext_ctrl[tpx_pkg::EC_PULLUP_SEL];
			always_ff @(posedge I_CLOCK or posedge I_RESET) begin
				if (I_RESET) begin
					O_PORT_FLOAT[gi] <= 1'b0;
					O_PORT_HIGH_IMP[gi] <= 1'b0;
				end else begin
					O_PORT_FLOAT[gi] <= next_port[gi].float_en;
					O_PORT_HIGH_IMP[gi] <= next_port[gi].high_imp;
				end
			end
		end
	endgenerate

	// read mux
	wire logic [31:0] rd_val = hit_ec ? {24'h00_0000, ext_ctrl} :
		hit_tm ? {24'h00_0000, tmr_mode} :
		hit_tc ? {28'h000_0000, ovf1, run1, ovf0, run0} :
		hit_pc ? {24'h00_0000, pwr_ctrl} :
		hit_c0 ? {16'h0000, cnt0} :
		hit_c1 ? {16'h0000, cnt1} :
		hit_st ? {27'h000_0000, wd_pending, O_WDOG_RESET, pwr_state} : 32'h0000_0000;

	// apb answer: no wait states, error on unmapped address
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= I_PSEL & ~I_PENABLE;
			O_PRDATA <= rd_val;
			O_PSLVERR <= I_PSEL & ~I_PENABLE & ~mapped;
		end
	end

	// software write and watchdog clear of the control register
	wire logic wd_clr = O_WDOG_RESET;
	wire logic bus_ok = wr & O_PREADY;
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			ext_ctrl <= tpx_pkg::EXT_CTRL_RST;
			tmr_mode <= tpx_pkg::BYTE_ZERO;
		end else if (wd_clr) begin
			ext_ctrl <= tpx_pkg::EXT_CTRL_RST;
			tmr_mode <= tpx_pkg::BYTE_ZERO;
		end else begin
			if (bus_ok & hit_ec) ext_ctrl <= I_PWDATA[7:0];
			if (bus_ok & hit_tm) tmr_mode <= I_PWDATA[7:0];
		end
	end

	// timer control bits; hardware set wins over software clear
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			run0 <= 1'b0;
			run1 <= 1'b0;
			ovf0 <= 1'b0;
			ovf1 <= 1'b0;
		end else if (wd_clr) begin
			run0 <= 1'b0;
			run1 <= 1'b0;
			ovf0 <= 1'b0;
			ovf1 <= 1'b0;
		end else begin
			if (bus_ok & hit_tc) begin
				run0 <= I_PWDATA[tpx_pkg::TC_RUN0];
				run1 <= I_PWDATA[tpx_pkg::TC_RUN1];
			end
			ovf0 <= set_ovf0 | ((bus_ok & hit_tc) ? I_PWDATA[tpx_pkg::TC_OVF0] : ovf0);
			ovf1 <= ov1 | ((bus_ok & hit_tc) ? I_PWDATA[tpx_pkg::TC_OVF1] : ovf1);
		end
	end

	// counters
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			cnt0 <= tpx_pkg::CNT_RST;
			cnt1 <= tpx_pkg::CNT_RST;
		end else if (wd_clr) begin
			cnt0 <= tpx_pkg::CNT_RST;
			cnt1 <= tpx_pkg::CNT_RST;
		end else begin
			if (bus_ok & hit_c0) cnt0 <= I_PWDATA[15:0];
			else if (en0) cnt0 <= nx0;
			if (bus_ok & hit_c1) cnt1 <= I_PWDATA[15:0];
			else if (step1) cnt1 <= nx1;
		end
	end

	// pin samplers
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			t0_prev <= 1'b0;
			t1_prev <= 1'b0;
			t1_pin_prev <= 1'b1; // idle-high pin: no false rising edge after reset
		end else begin
			if (samp) t0_prev <= I_TIMER_ZERO_PIN;
			if (samp) t1_prev <= I_TIMER_ONE_PIN;
			t1_pin_prev <= I_TIMER_ONE_PIN;
		end
	end

	// watchdog reset: pending one machine cycle, then five machine cycles long
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			wd_pending <= 1'b0;
			wd_count <= 3'h0;
			O_WDOG_RESET <= 1'b0;
		end else if (wd_fire) begin
			wd_pending <= 1'b1;
		end else if (wd_pending & (I_MACHINE_CYCLE | in_pd)) begin
			wd_pending <= 1'b0;
			O_WDOG_RESET <= 1'b1;
			wd_count <= tpx_pkg::WDOG_RST_LEN;
		end else if (O_WDOG_RESET & I_MACHINE_CYCLE) begin
			wd_count <= wd_count - 3'h1;
			if (wd_count == 3'h1) O_WDOG_RESET <= 1'b0;
		end
	end

	// power state machine
	tpx_pkg::tpx_pwr_t next_pwr;
	wire logic idle_req = bus_ok & hit_pc & I_PWDATA[tpx_pkg::PC_IDLE];
	wire logic pd_req = (bus_ok & hit_pc & I_PWDATA[tpx_pkg::PC_PD]) | (pin_pd & t1_fall);
	always_comb begin
		next_pwr = pwr_state;
		case (pwr_state)
			tpx_pkg::PW_RUN: begin
				if (pd_req) next_pwr = tpx_pkg::PW_DOWN;
				else if (idle_req) next_pwr = tpx_pkg::PW_IDLE;
			end
			tpx_pkg::PW_IDLE: begin
				if (idle_exit) next_pwr = tpx_pkg::PW_RUN;
			end
			tpx_pkg::PW_DOWN: begin
				if (pd_exit) next_pwr = tpx_pkg::PW_RUN;
			end
			default: next_pwr = tpx_pkg::PW_RUN;
		endcase
		if (wd_clr) next_pwr = tpx_pkg::PW_RUN;
	end

	wire logic waking = (pwr_state == tpx_pkg::PW_IDLE & idle_exit) | (in_pd & pd_exit);
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			pwr_state <= tpx_pkg::PW_RUN;
			pwr_ctrl <= tpx_pkg::BYTE_ZERO;
			pin_pd_armed <= 1'b0;
			O_POWERDOWN <= 1'b0;
			O_IDLE <= 1'b0;
			O_WAKE_RESUME <= 1'b0;
			O_WAKE_SERVICE <= 1'b0;
			O_TIMER0_IRQ <= 1'b0;
			O_TIMER1_IRQ <= 1'b0;
		end else begin
			pwr_state <= next_pwr;
			if (wd_clr) pwr_ctrl <= tpx_pkg::BYTE_ZERO;
			else if (bus_ok & hit_pc) pwr_ctrl <= I_PWDATA[7:0];
			else if (waking) pwr_ctrl <= pwr_ctrl & 8'hFC;
			pin_pd_armed <= in_pd & (pin_pd_armed | t1_rise);
			O_POWERDOWN <= next_pwr == tpx_pkg::PW_DOWN;
			O_IDLE <= next_pwr == tpx_pkg::PW_IDLE;
			O_WAKE_RESUME <= waking & recover;
			O_WAKE_SERVICE <= waking & ~recover;
			O_TIMER0_IRQ <= set_ovf0 | (ovf0 & ~(bus_ok & hit_tc));
			O_TIMER1_IRQ <= (ov1 | ovf1) & ~wdog;
		end
	end
endmodule : tpx_top

// ===== testbench/tpx_pin_model.sv
// machine-cycle strobe and timer-zero count pin as seen from outside the block
`timescale 1ns/100ps
module tpx_pin_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control from the bench
	input wire logic mc_en,
	input wire logic pin_en,
	// strobe and pin
	output logic mc,
	output logic pin0
);
	logic [3:0] cnt;
	// one strobe per twelve clocks; the pin changes at most once per machine cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			mc <= 1'b0;
			pin0 <= 1'b0;
		end else begin
			cnt <= (!mc_en || cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
			mc <= mc_en && cnt == 4'hA;
			if (mc && pin_en) pin0 <= !pin0;
		end
	end
endmodule : tpx_pin_model

// ===== testbench/tpx_top_properties.sv
// port-level assertions for the timer, watchdog and power-down block
`timescale 1ns/100ps
module tpx_properties #(
	parameter int NUM_PORTS = 3
) (
	// clock, reset and bus
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	// pins and control outputs
	input wire logic I_MACHINE_CYCLE,
	input wire logic I_EXT_INT0,
	input wire logic I_EXT_INT1,
	input wire logic [NUM_PORTS-1:0] O_PORT_FLOAT,
	input wire logic [NUM_PORTS-1:0] O_PORT_HIGH_IMP,
	input wire logic O_WDOG_RESET,
	input wire logic O_POWERDOWN,
	input wire logic O_WAKE_RESUME,
	input wire logic O_WAKE_SERVICE
);
	logic [7:0] ext;
	logic [2:0] mcn;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	// shadow of the control register, cleared by the watchdog reset
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) ext <= 8'h00;
		else if (O_WDOG_RESET) ext <= 8'h00;
		else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && !O_PSLVERR
			&& I_PADDR == tpx_pkg::ADDR_EXT_CTRL) ext <= I_PWDATA[7:0];
	end
	// machine cycles seen while the watchdog reset stands
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) mcn <= 3'h0;
		else if (!O_WDOG_RESET) mcn <= 3'h0;
		else if (I_MACHINE_CYCLE) mcn <= mcn + 3'h1;
	end
	a_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
		else $error("ready missing after setup");
	a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	a_error_with_ready: assert property (O_PSLVERR |-> O_PREADY)
		else $error("error without ready");
	a_port_float_normal: assert property (!O_POWERDOWN && !$past(O_POWERDOWN) && $stable(ext)
		|-> O_PORT_FLOAT == ext[3:1]) else $error("port float differs from control");
	a_float_on_entry: assert property ($rose(O_POWERDOWN) && ext[0] && !I_EXT_INT0 && !I_EXT_INT1
		|=> O_PORT_FLOAT == 3'b111) else $error("ports not floating in power-down");
	a_high_imp_select: assert property (!O_POWERDOWN && !$past(O_POWERDOWN) && $stable(ext)
		|-> (O_PORT_HIGH_IMP & ~ext[3:1]) == ({3{ext[4]}} & ~ext[3:1]))
		else $error("impedance select differs");
	a_wdog_length: assert property ($fell(O_WDOG_RESET) |-> mcn == 3'h5)
		else $error("watchdog reset length wrong");
	a_wdog_clears: assert property (O_WDOG_RESET && $past(O_WDOG_RESET, 2)
		|-> O_PORT_FLOAT == 3'b000 && !O_POWERDOWN) else $error("watchdog reset left state");
	a_wake_exclusive: assert property (!(O_WAKE_RESUME && O_WAKE_SERVICE))
		else $error("resume and service together");
	a_wake_pulse: assert property (O_WAKE_RESUME || O_WAKE_SERVICE
		|=> !O_WAKE_RESUME && !O_WAKE_SERVICE) else $error("wake pulse too long");
	c_wdog: cover property ($fell(O_WDOG_RESET));
	c_pd: cover property ($rose(O_POWERDOWN));
	c_resume: cover property (O_WAKE_RESUME);
endmodule : tpx_properties
bind tpx_top tpx_properties #(.NUM_PORTS(NUM_PORTS)) u_props (.*);

// ===== testbench/tpx_top_tb_top.sv
// self-checking bench for the timer, watchdog and power-down block
`timescale 1ns/100ps
module tpx_top_tb_top;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, mc_en = 1'b0;
	logic pin_en = 1'b0, int0 = 1'b0, t1pin = 1'b1, mc, t0pin, errv;
	logic pready, pslverr, wdr, pd, irq1, wres, wsrv, idl;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [2:0] pfl, phi;
	int failures = 0, check_count = 0, nres = 0, nsrv = 0, nwd = 0, kr, ks;
	always #2.5 clk = ~clk;
	tpx_pin_model model (.clk(clk), .rst(rst), .mc_en(mc_en), .pin_en(pin_en), .mc(mc), .pin0(t0pin));
	tpx_top uut (.I_CLOCK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_MACHINE_CYCLE(mc), .I_TIMER_ZERO_PIN(t0pin),
		.I_TIMER_ONE_PIN(t1pin), .I_EXT_INT0(int0), .I_EXT_INT1(1'b0), .O_PORT_FLOAT(pfl),
		.O_PORT_HIGH_IMP(phi), .O_WDOG_RESET(wdr), .O_POWERDOWN(pd), .O_IDLE(idl),
		.O_TIMER0_IRQ(), .O_TIMER1_IRQ(irq1), .O_WAKE_RESUME(wres), .O_WAKE_SERVICE(wsrv));
	// counts of wake pulses and watchdog reset cycles
	always @(posedge clk) begin
		nres <= nres + int'(wres);
		nsrv <= nsrv + int'(wsrv);
		nwd <= nwd + int'(wdr);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one bus transfer: setup, access until ready, release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		rd = prdata;
		errv = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// let registered outputs settle before the caller looks at them
		repeat (2) @(posedge clk);
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask : rdchk
	// let n machine-cycle strobes through, then stop them
	task automatic ticks(input int n);
		mc_en <= 1'b1;
		repeat (n) begin
			do @(negedge clk); while (mc !== 1'b1);
			@(posedge clk);
		end
		mc_en <= 1'b0;
		@(posedge clk);
	endtask : ticks
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// reset state, unmapped place, port impedance
		rdchk(tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
		check(32'(phi), 32'h0000_0000);
		rdchk(8'h1C, 32'h0000_0000);
		check(32'(errv), 32'h0000_0001);
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0012);
		check(32'(pfl), 32'h0000_0001);
		check(32'(phi & 3'b110), 32'h0000_0006);
		rdchk(tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0012);
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
		$display("test ports done");
		// chained timer wraps, then timer0 keeps the low half
		apb(1'b1, tpx_pkg::ADDR_TMR0_CNT, 32'h0000_FFFF);
		apb(1'b1, tpx_pkg::ADDR_TMR1_CNT, 32'h0000_FFFF);
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0040);
		ticks(2);
		rdchk(tpx_pkg::ADDR_TMR_CTRL, 32'h0000_0008);
		check(32'(irq1), 32'h0000_0001);
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
		apb(1'b1, tpx_pkg::ADDR_TMR_CTRL, 32'h0000_0000);
		ticks(2);
		rdchk(tpx_pkg::ADDR_TMR0_CNT, 32'h0000_0001);
		rdchk(tpx_pkg::ADDR_TMR1_CNT, 32'h0000_0000);
		$display("test chain done");
		// chained watchdog overflows and resets the registers
		apb(1'b1, tpx_pkg::ADDR_TMR0_CNT, 32'h0000_FFFF);
		apb(1'b1, tpx_pkg::ADDR_TMR1_CNT, 32'h0000_FFFF);
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_00C2);
		ticks(9);
		check(32'(nwd > 0), 32'h0000_0001);
		rdchk(tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
		rdchk(tpx_pkg::ADDR_TMR0_CNT, 32'h0000_0000);
		check(32'(pfl), 32'h0000_0000);
		$display("test watchdog done");
		// event counter: one count per sampled one then zero
		apb(1'b1, tpx_pkg::ADDR_TMR_MODE, 32'h0000_0004);
		pin_en <= 1'b1;
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0040);
		ticks(8);
		apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
		pin_en <= 1'b0;
		rdchk(tpx_pkg::ADDR_TMR0_CNT, 32'h0000_0003);
		$display("test counter done");
		// power-down with floating ports, woken by an interrupt
		for (int r = 0; r < 2; r++) begin
			kr = nres;
			ks = nsrv;
			apb(1'b1, tpx_pkg::ADDR_EXT_CTRL, 32'h0000_0001);
			apb(1'b1, tpx_pkg::ADDR_PWR_CTRL, r ? 32'h0000_0006 : 32'h0000_0002);
			check(32'(pd), 32'h0000_0001);
			check(32'(pfl), 32'h0000_0007);
			int0 <= 1'b1;
			repeat (4) @(posedge clk);
			int0 <= 1'b0;
			@(negedge clk);
			check(32'(pd), 32'h0000_0000);
			check(32'(pfl), 32'h0000_0000);
			check(nres - kr, r);
			check(nsrv - ks, 1 - r);
			@(posedge clk);
		end
		$display("test powerdown done");
		// power-down by the timer-one pin edges
		apb(1'b1, tpx_pkg::ADDR_PWR_CTRL, 32'h0000_0008);
		t1pin <= 1'b0;
		repeat (3) @(negedge clk);
		check(32'(pd), 32'h0000_0001);
		@(posedge clk);
		t1pin <= 1'b1;
		repeat (3) @(negedge clk);
		check(32'(pd), 32'h0000_0000);
		$display("test pin powerdown done");
		// idle with recover bit, woken by an interrupt
		@(posedge clk);
		kr = nres;
		apb(1'b1, tpx_pkg::ADDR_PWR_CTRL, 32'h0000_0005);
		check(32'(idl), 32'h0000_0001);
		int0 <= 1'b1;
		repeat (3) @(posedge clk);
		int0 <= 1'b0;
		@(posedge clk);
		check(32'(idl), 32'h0000_0000);
		check(nres - kr, 1);
		$display("test idle done");
		print_verdict();
	end
endmodule : tpx_top_tb_top
